// file: core/afc_top.sv
// Purpose: Temperature-driven two-fan PWM loop with filtered ramping, reached over APB.
// Assumes: Temperatures are unsigned whole degrees from logic on ref_clk; they need no synchroniser.
// Notes: Each rule below is tagged at the logic that carries it out.
// Function
// (R1) Main config bit 7 picks automatic loop (1, reset) or software duty.
// (R2) Main config bits 6:5 route channels to fans, 11 takes highest speed.
// (R3) Characteristics bits 2:0 pick spin-up time 200 ms to 8 s, reset 2 s.
// (R4) Characteristics bits 5:3 pick PWM frequency 11.7 to 93.5 Hz, reset 31.25.
// (R5) Characteristics bits 7:6 hold the speed range divisor 1, 2, 4, 8; the loop stores these bits but never uses them.
// (R6) Low nibble of minimum duty register is fan 1 start code, reset 5.
// (R7) High nibble of minimum duty register is fan 2 start code.
// (R8) Limit bits 7:3 set start temperature in 4 degree steps, 0 to 124.
// (R9) Limit bits 2:0 set control span 5, 10, 20, 40 or 80 degrees.
// (R10) Each remote channel has its own limit register with identical encoding.
// (R11) Without filtering a new computed duty reaches the output at once.
// (R12) Filter register bit 0 enables filtering on fan 1, bit 1 on fan 2.
// (R13) Software programs filter and loop parameters before setting the automatic bit.
// (R14) Each PWM period is 240 slots; output high for duty slots, then low.
// (R15) A 33 percent duty is 80 high slots then 160 low slots.
// (R16) Filtered duty steps toward the new target and is stored as previous.
// (R17) Filter bits 6:5 choose ramp step of 1, 2, 4 or 8 slots.
// (R18) Filter bits 4:2 choose converter sample rate, 1.4 kHz at reset.
// (R19) Filtered ramp runs once per temperature update, 0.0625 to 8 per second.
// (R20) Ramp step code 00 is 1 slot up to 11 for 8 slots.
// (R21) Sample rate code 000 is 87.5 Hz doubling up to 111 at 11.2 kHz.
// (R22) Duty code rises one per tenth of span above start, saturating at 15.
// (R23) A filtered step is clamped so it never passes the target.
// (R24) Highest-speed routing computes every channel and drives both fans with the largest.
//
// The APB interface to the registers was chosen for this implementation.

`timescale 1ns/1ps

module afc_top #(
    parameter int unsigned CLK_HZ = 40000000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Temperatures
    input wire logic [7:0] temp_local,
    input wire logic [7:0] temp_remote1,
    input wire logic [7:0] temp_remote2,
    // Fan drive
    output logic pwm_fan1,
    output logic pwm_fan2
);

    // ------------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------------
    localparam int unsigned TICK_CYC = int'((64'(CLK_HZ) * afc_pkg::TICK_US) / 64'd1000000);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam logic [15:0] UPD_FAST_TICKS = 16'((afc_pkg::UPD_FAST_MS * 1000) / afc_pkg::TICK_US);

    function automatic logic [15:0] slot_cycles(input int unsigned k);
        return 16'((64'(CLK_HZ) * 64'd1000) / (64'd240 * 64'(afc_pkg::FREQ_MHZ[k])));
    endfunction

    function automatic logic [15:0] spin_ticks(input logic [2:0] k);
        return 16'((afc_pkg::SPIN_MS[k] * 1000) / afc_pkg::TICK_US);
    endfunction

    if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_tick_chk
        $error("CLK_HZ gives a tick count outside 16 bits");
    end
    if ((64'(CLK_HZ) * 64'd1000) / (64'd240 * 64'(afc_pkg::FREQ_MHZ[0])) > 64'd65535 ||
        (64'(CLK_HZ) * 64'd1000) / (64'd240 * 64'(afc_pkg::FREQ_MHZ[7])) < 64'd1) begin : g_slot_chk
        $error("CLK_HZ gives a PWM slot count outside 1 to 65535 cycles");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] main_cfg;
        logic [7:0] fan1_char;
        logic [7:0] fan2_char;
        logic [7:0] min_duty;
        logic [7:0] filter;
        logic [7:0] local_lim;
        logic [7:0] remote1_lim;
        logic [7:0] remote2_lim;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] tick_cnt;
        logic [15:0] upd_cnt;
        logic [1:0][7:0] duty;
        logic [1:0][7:0] cur;
        logic [1:0][15:0] pre_cnt;
        logic [1:0][7:0] slot;
        logic [1:0][15:0] spin_cnt;
        logic [1:0] spinning;
        logic [1:0] was_on;
        logic [1:0] pwm;
    } afc_state_t;

    localparam afc_state_t ST_RST = '{
        main_cfg: afc_pkg::RST_MAIN_CFG,
        fan1_char: afc_pkg::RST_FAN_CHAR,
        fan2_char: afc_pkg::RST_FAN_CHAR,
        min_duty: afc_pkg::RST_MIN_DUTY,
        filter: afc_pkg::RST_FILTER,
        local_lim: afc_pkg::RST_LIMITS,
        remote1_lim: afc_pkg::RST_LIMITS,
        remote2_lim: afc_pkg::RST_LIMITS,
        default: '0
    };

    afc_state_t s_r;
    afc_state_t s_nxt;

    // ------------------------------------------------------------------
    // Loop arithmetic
    // ------------------------------------------------------------------
    // Duty code of one channel: start code at the start temperature, one more per
    // tenth of the span. Span/10 is 0.5..8 degrees, so the division is a shift.
    function automatic logic [3:0] chan_code(input logic [7:0] temp, input logic [7:0] lim,
                                             input logic [3:0] start_code);
        logic [8:0] start_temp;
        logic [8:0] diff;
        logic [9:0] inc;
        logic [10:0] sum;
        start_temp = {2'b00, lim[afc_pkg::LIM_START_LSB +: 5], 2'b00}; // see (R8)
        diff = 9'({1'b0, temp} - start_temp);
        inc = '0;
        sum = '0;
        if ({1'b0, temp} < start_temp) begin
            return 4'h0;
        end
        unique case (lim[afc_pkg::LIM_SPAN_LSB +: 3]) // see (R9)
            3'd0: inc = {diff, 1'b0};
            3'd1: inc = {1'b0, diff};
            3'd2: inc = {2'b00, diff[8:1]};
            3'd3: inc = {3'b000, diff[8:2]};
            default: inc = {4'h0, diff[8:3]};
        endcase
        sum = 11'(inc) + 11'(start_code);
        if (sum > 11'(afc_pkg::FULL_DUTY_CODE)) begin // see (R22)
            return afc_pkg::FULL_DUTY_CODE;
        end
        return sum[3:0];
    endfunction

    function automatic logic [3:0] max3(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
        logic [3:0] m;
        m = (a > b) ? a : b;
        return (c > m) ? c : m;
    endfunction

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function automatic logic [8:0] read_reg(input afc_state_t s, input logic [5:0] idx);
        unique case (idx)
            afc_pkg::IDX_MAIN_CFG: return {1'b1, s.main_cfg};
            afc_pkg::IDX_FAN1_CHAR: return {1'b1, s.fan1_char};
            afc_pkg::IDX_FAN2_CHAR: return {1'b1, s.fan2_char};
            afc_pkg::IDX_MIN_DUTY: return {1'b1, s.min_duty};
            afc_pkg::IDX_FILTER: return {1'b1, s.filter};
            afc_pkg::IDX_LOCAL_LIM: return {1'b1, s.local_lim};
            afc_pkg::IDX_REMOTE1_LIM: return {1'b1, s.remote1_lim};
            afc_pkg::IDX_REMOTE2_LIM: return {1'b1, s.remote2_lim};
            afc_pkg::IDX_FAN1_DUTY: return {1'b1, s.duty[0]};
            afc_pkg::IDX_FAN2_DUTY: return {1'b1, s.duty[1]};
            afc_pkg::IDX_FAN_STATUS: return {1'b1, 4'h0, s.was_on, s.spinning};
            default: return 9'h000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [8:0] rd;
        logic [5:0] idx;
        logic wr_en;
        logic tick;
        logic upd;
        logic [15:0] upd_period;
        logic auto_mode;
        logic [1:0] route;
        logic [7:0] fchar;
        logic [3:0] start_code;
        logic [3:0] c_loc;
        logic [3:0] c_r1;
        logic [3:0] c_r2;
        logic [3:0] code;
        logic [7:0] target;
        logic [7:0] step;
        logic [15:0] slot_last;
        logic on;
        s_nxt = s_r;
        idx = paddr[7:2];
        rd = read_reg(s_r, idx);
        wr_en = 1'b0;
        tick = 1'b0;
        upd = 1'b0;
        upd_period = '0;
        auto_mode = s_r.main_cfg[afc_pkg::CFG_AUTO_BIT];
        route = s_r.main_cfg[afc_pkg::CFG_ROUTE_LSB +: 2];
        fchar = '0;
        start_code = '0;
        c_loc = '0;
        c_r1 = '0;
        c_r2 = '0;
        code = '0;
        target = '0;
        step = '0;
        slot_last = '0;
        on = 1'b0;

        // APB: answer is prepared in the setup cycle, so pready comes from a flop
        // and every access completes in its first access cycle.
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = ~rd[8] | (paddr[1:0] != 2'b00);
            s_nxt.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd[7:0]};
        end
        wr_en = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
        if (wr_en) begin
            unique case (idx)
                // The loop acts on new settings at once; ordering writes is software's job.
                afc_pkg::IDX_MAIN_CFG: s_nxt.main_cfg = pwdata[7:0]; // see (R1) (R2) (R13)
                afc_pkg::IDX_FAN1_CHAR: s_nxt.fan1_char = pwdata[7:0]; // see (R3) (R4) (R5)
                afc_pkg::IDX_FAN2_CHAR: s_nxt.fan2_char = pwdata[7:0]; // see (R3) (R4) (R5)
                afc_pkg::IDX_MIN_DUTY: s_nxt.min_duty = pwdata[7:0]; // see (R6) (R7)
                afc_pkg::IDX_FILTER: s_nxt.filter = pwdata[7:0]; // see (R12) (R17) (R18)
                afc_pkg::IDX_LOCAL_LIM: s_nxt.local_lim = pwdata[7:0]; // see (R8) (R9)
                afc_pkg::IDX_REMOTE1_LIM: s_nxt.remote1_lim = pwdata[7:0]; // see (R10)
                afc_pkg::IDX_REMOTE2_LIM: s_nxt.remote2_lim = pwdata[7:0]; // see (R10)
                default: ;
            endcase
        end

        // Half-millisecond tick and temperature update strobe.
        tick = (s_r.tick_cnt >= TICK_LAST);
        s_nxt.tick_cnt = tick ? 16'h0000 : 16'(s_r.tick_cnt + 16'h0001);
        upd_period = 16'(UPD_FAST_TICKS << (3'd7 - s_r.filter[afc_pkg::FLT_RATE_LSB +: 3])); // see (R19) (R21)
        if (tick) begin
            if (s_r.upd_cnt >= 16'(upd_period - 16'h0001)) begin
                s_nxt.upd_cnt = 16'h0000;
                upd = 1'b1;
            end else begin
                s_nxt.upd_cnt = 16'(s_r.upd_cnt + 16'h0001);
            end
        end
        step = 8'(8'h01 << s_r.filter[afc_pkg::FLT_STEP_LSB +: 2]); // see (R17) (R20)

        for (int i = 0; i < 2; i++) begin
            fchar = (i == 0) ? s_r.fan1_char : s_r.fan2_char;
            start_code = s_r.min_duty[i * 4 +: 4]; // see (R6) (R7)
            c_loc = chan_code(temp_local, s_r.local_lim, start_code);
            c_r1 = chan_code(temp_remote1, s_r.remote1_lim, start_code); // see (R10)
            c_r2 = chan_code(temp_remote2, s_r.remote2_lim, start_code);
            unique case (route) // see (R2)
                afc_pkg::ROUTE_SPLIT: code = (i == 0) ? c_r1 : c_r2;
                afc_pkg::ROUTE_R1: code = c_r1;
                afc_pkg::ROUTE_R2: code = c_r2;
                afc_pkg::ROUTE_MAX: code = max3(c_loc, c_r1, c_r2); // see (R24)
            endcase
            // Code 15 times 16 is exactly 240 slots, so codes map linearly onto the period.
            target = auto_mode ? {code, 4'h0} : {start_code, 4'h0}; // see (R1) (R22)

            if (auto_mode && s_r.filter[i]) begin // see (R12)
                if (upd) begin // see (R16) (R19)
                    if (target > s_r.duty[i]) begin
                        s_nxt.duty[i] = (8'(target - s_r.duty[i]) <= step) ? target
                                        : 8'(s_r.duty[i] + step); // see (R23)
                    end else if (target < s_r.duty[i]) begin
                        s_nxt.duty[i] = (8'(s_r.duty[i] - target) <= step) ? target
                                        : 8'(s_r.duty[i] - step); // see (R23)
                    end
                end
            end else begin
                s_nxt.duty[i] = target; // see (R11)
            end

            // Spin-up: a fan leaving standstill runs full for the programmed time.
            on = (s_nxt.duty[i] != 8'h00);
            s_nxt.was_on[i] = on;
            if (!on) begin
                s_nxt.spinning[i] = 1'b0;
            end else if (!s_r.was_on[i] && !s_r.filter[afc_pkg::FLT_SPIN_DIS_BIT]) begin
                s_nxt.spinning[i] = 1'b1;
                s_nxt.spin_cnt[i] = 16'h0000;
            end else if (s_r.spinning[i] && tick) begin
                if (s_r.spin_cnt[i] >= 16'(spin_ticks(fchar[afc_pkg::CHAR_SPIN_LSB +: 3]) - 16'h0001)) begin // see (R3)
                    s_nxt.spinning[i] = 1'b0;
                end else begin
                    s_nxt.spin_cnt[i] = 16'(s_r.spin_cnt[i] + 16'h0001);
                end
            end

            // PWM: 240 slots per period; the duty is latched at the period start so a
            // change mid-period cannot produce a runt pulse.
            slot_last = 16'(slot_cycles(int'(fchar[afc_pkg::CHAR_FREQ_LSB +: 3])) - 16'h0001); // see (R4)
            if (s_r.pre_cnt[i] >= slot_last) begin
                s_nxt.pre_cnt[i] = 16'h0000;
                if (s_r.slot[i] >= 8'(afc_pkg::SLOTS_PER_PERIOD - 8'h01)) begin // see (R14)
                    s_nxt.slot[i] = 8'h00;
                    s_nxt.cur[i] = s_nxt.duty[i];
                end else begin
                    s_nxt.slot[i] = 8'(s_r.slot[i] + 8'h01);
                end
            end else begin
                s_nxt.pre_cnt[i] = 16'(s_r.pre_cnt[i] + 16'h0001);
            end
            s_nxt.pwm[i] = s_nxt.spinning[i] | (s_nxt.slot[i] < s_nxt.cur[i]); // see (R14) (R15)
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign pwm_fan1 = s_r.pwm[0];
    assign pwm_fan2 = s_r.pwm[1];

endmodule

// file: core/afc_pkg.sv
// Purpose: Constants shared by the automatic fan loop: register map, field layout, reset values, timing.
// Assumes: Registers are 8 bits wide and sit one per aligned 32-bit APB word at four times their index.
// Notes: Times are kept in their own units; cycle counts are derived in the top module from its clock rate.

package afc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_MAIN_CFG = 6'h00;
    localparam logic [5:0] IDX_FAN1_CHAR = 6'h20;
    localparam logic [5:0] IDX_FAN2_CHAR = 6'h21;
    localparam logic [5:0] IDX_MIN_DUTY = 6'h22;
    localparam logic [5:0] IDX_FILTER = 6'h23;
    localparam logic [5:0] IDX_LOCAL_LIM = 6'h24;
    localparam logic [5:0] IDX_REMOTE1_LIM = 6'h25;
    localparam logic [5:0] IDX_REMOTE2_LIM = 6'h26;
    localparam logic [5:0] IDX_FAN1_DUTY = 6'h27;
    localparam logic [5:0] IDX_FAN2_DUTY = 6'h28;
    localparam logic [5:0] IDX_FAN_STATUS = 6'h29;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_AUTO_BIT = 7;
    localparam int CFG_ROUTE_LSB = 5;
    localparam int CHAR_SPIN_LSB = 0;
    localparam int CHAR_FREQ_LSB = 3;
    localparam int CHAR_RANGE_LSB = 6;
    localparam int FLT_SPIN_DIS_BIT = 7;
    localparam int FLT_STEP_LSB = 5;
    localparam int FLT_RATE_LSB = 2;
    localparam int LIM_START_LSB = 3;
    localparam int LIM_SPAN_LSB = 0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] ROUTE_SPLIT = 2'h0;
    localparam logic [1:0] ROUTE_R1 = 2'h1;
    localparam logic [1:0] ROUTE_R2 = 2'h2;
    localparam logic [1:0] ROUTE_MAX = 2'h3;
    localparam logic [3:0] FULL_DUTY_CODE = 4'hF;
    localparam logic [7:0] SLOTS_PER_PERIOD = 8'hF0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_CFG = 8'h80;
    localparam logic [7:0] RST_FAN_CHAR = 8'h1D;
    localparam logic [7:0] RST_MIN_DUTY = 8'h55;
    localparam logic [7:0] RST_FILTER = 8'h10;
    localparam logic [7:0] RST_LIMITS = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned TICK_US = 500;
    localparam int unsigned UPD_FAST_MS = 125;
    localparam int unsigned SPIN_MS [8] = '{200, 400, 600, 800, 1000, 2000, 4000, 8000};
    localparam int unsigned FREQ_MHZ [8] = '{11700, 15600, 23400, 31250, 37500, 46900, 62500, 93500};

endpackage

// file: dv/afc_props.sv
// Purpose: Assertions on the register bus answers of the automatic fan loop.
// Assumes: Zero wait states, one answer cycle for each transfer.
// Notes: Bound to the top module from the bench top file.
`timescale 1ns/1ps
module afc_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Fan drive
    input wire logic pwm_fan1,
    input wire logic pwm_fan2
);
    default clocking dclk @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    ready_on_time_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("answer without a setup cycle");
    err_align_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    err_hole_a: assert property (pready && paddr[7:2] inside {[6'h01:6'h1F]}
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    map_ok_a: assert property (pready && paddr[1:0] == 2'b00 && paddr[7:2] inside {[6'h20:6'h29]} |-> !pslverr)
        else $error("mapped access refused");
    err_lone_a: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    data_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    cover property (pready && pwrite);
    cover property (pready && pslverr);
    cover property ($rose(pwm_fan1));
    cover property ($rose(pwm_fan2));
endmodule

// file: dv/afc_fan_model.sv
// Purpose: Fan stand-in that measures high time and period of its drive.
// Assumes: Each drive period begins with its high part.
// Notes: The first figures after reset cover a partial period.
`timescale 1ns/1ps
module afc_fan_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Drive and measurement
    input wire logic pwm,
    output logic [15:0] hi_cnt,
    output logic [15:0] per_cnt
);
    logic pwm_q;
    logic [15:0] hi_run;
    logic [15:0] per_run;
    // A rising drive opens a period, so the figures of the closed one are published then.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
            hi_run <= 16'h0000;
            per_run <= 16'h0000;
            hi_cnt <= 16'h0000;
            per_cnt <= 16'h0000;
        end else begin
            pwm_q <= pwm;
            if (pwm && !pwm_q) begin
                hi_cnt <= hi_run;
                per_cnt <= per_run;
                hi_run <= 16'h0001;
                per_run <= 16'h0001;
            end else begin
                hi_run <= hi_run + {15'h0000, pwm};
                per_run <= per_run + 16'h0001;
            end
        end
    end
endmodule

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the automatic two-fan loop.
// Assumes: CLK_HZ lowered so a slot at the fastest rate is one clock and a tick is 11 clocks.
// Notes: Bus answers are matched against queued notes by a watcher process.
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] t_loc = 8'h00;
    logic [7:0] t_r1 = 8'h00;
    logic [7:0] t_r2 = 8'h00;
    logic [31:0] prdata, q;
    logic pready, pslverr, pwm_fan1, pwm_fan2;
    logic [15:0] hi1, per1, hi2, per2;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic [7:0] tv[3];
    logic [7:0] lims[3];
    int errors = 0;
    int checked = 0;
    int cyc = 0;

    always #12.5 ref_clk = ~ref_clk;

    afc_top #(.CLK_HZ(22440)) dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .temp_local(t_loc), .temp_remote1(t_r1), .temp_remote2(t_r2), .pwm_fan1, .pwm_fan2);
    afc_fan_model fan_a (.ref_clk, .rst_n, .pwm(pwm_fan1), .hi_cnt(hi1), .per_cnt(per1));
    afc_fan_model fan_b (.ref_clk, .rst_n, .pwm(pwm_fan2), .hi_cnt(hi2), .per_cnt(per2));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Mode bit 1 asks for a data compare, bit 0 says a refusal is expected.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] m,
        input logic [7:0] e);
        notes.push_back({m, 24'h00_0000, e});
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, {i, 2'b00}, d, 2'b00, 8'h00);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, {i, 2'b00}, 8'h00, 2'b10, e);
    endtask

    function automatic logic [7:0] duty(input logic [7:0] t, input logic [7:0] lim, input logic [3:0] mc);
        int s;
        int c;
        s = lim[7:3] * 4;
        c = (t < s) ? 0 : mc + (t - s) * 10 / ((lim[2:0] > 3'h4) ? 80 : 5 << lim[2:0]);
        return 8'((c > 15) ? 240 : c * 16);
    endfunction

    // Source 3 takes the fastest of all three channels.
    function automatic logic [7:0] fan_exp(input int src, input logic [3:0] mc);
        logic [7:0] m;
        m = 8'h00;
        for (int j = 0; j < 3; j++) begin
            if ((src == j || src == 3) && duty(tv[j], lims[j], mc) > m) m = duty(tv[j], lims[j], mc);
        end
        return m;
    endfunction

    always @(negedge ref_clk) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
            if (nt[33]) chk("prdata", nt[31:0], prdata);
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] prev;
        logic [1:0] stp[8];
        logic [7:0] ramp[8];
        int r;
        int n;
        int last;
        void'($urandom(32'h3fa5));
        stp = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h1, 2'h3, 2'h3};
        ramp = '{8'h01, 8'h02, 8'h0A, 8'h10, 8'h0C, 8'h0A, 8'h02, 8'h00};
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(6'h00, 8'h80);
        rd(6'h20, 8'h1D);
        rd(6'h21, 8'h1D);
        rd(6'h22, 8'h55);
        rd(6'h23, 8'h10);
        for (int i = 0; i < 3; i++) rd(6'(36 + i), 8'h00);
        bus(1'b0, 8'h04, 8'h00, 2'b11, 8'h00);
        bus(1'b0, 8'h81, 8'h00, 2'b01, 8'h00);
        bus(1'b1, 8'h9C, 8'hFF, 2'b00, 8'h00);
        rd(6'h27, 8'h50);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            r = (i == 0) ? 0 : 31 + i;
            wr(6'(r), v);
            rd(6'(r), v);
        end
        // Spin-up is kept off here so the PWM measured later is not masked by forced drive.
        wr(6'h23, 8'h9C);
        wr(6'h20, 8'h38);
        wr(6'h21, 8'h38);
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 3; j++) begin
                lims[j] = {5'($urandom_range(0, 15)), 3'($urandom_range(0, 4))};
                tv[j] = 8'($urandom_range(0, 90));
                wr(6'(36 + j), lims[j]);
            end
            v = 8'($urandom);
            wr(6'h22, v);
            t_loc <= tv[0];
            t_r1 <= tv[1];
            t_r2 <= tv[2];
            r = k % 4;
            wr(6'h00, {1'b1, 2'(r), 5'h00});
            rd(6'h27, fan_exp((r == 3) ? 3 : ((r == 2) ? 2 : 1), v[3:0]));
            rd(6'h28, fan_exp((r == 3) ? 3 : ((r == 1) ? 1 : 2), v[7:4]));
        end
        wr(6'h00, 8'h00);
        // Zero duty first ends any spin-up still running, so plain PWM is measured below.
        wr(6'h22, 8'h00);
        wr(6'h22, 8'hA5);
        rd(6'h28, 8'hA0);
        repeat (800) @(posedge ref_clk);
        chk("fan1 high", 32'h50, {16'h0, hi1});
        chk("fan1 period", 32'hF0, {16'h0, per1});
        chk("fan2 high", 32'hA0, {16'h0, hi2});
        wr(6'h22, 8'h30);
        wr(6'h23, 8'h9D);
        wr(6'h25, 8'h08);
        wr(6'h26, 8'h00);
        t_r1 <= 8'h00;
        t_r2 <= 8'h00;
        wr(6'h00, 8'h80);
        wr(6'h22, 8'h31);
        t_r1 <= 8'h04;
        rd(6'h28, 8'h30);
        prev = 8'h00;
        last = 0;
        for (int s = 0; s < 8; s++) begin
            if (s == 4) t_r1 <= 8'h00;
            wr(6'h23, {1'b1, stp[s], 3'b111, 2'b01});
            n = 0;
            do begin
                bus(1'b0, 8'h9C, 8'h00, 2'b00, 8'h00);
                n++;
            end while (q[7:0] === prev && n < 2500);
            chk("ramp duty", {24'h0, ramp[s]}, q);
            if (s > 0) chk("update gap", 32'h1, {31'h0, (cyc - last) > 2740 && (cyc - last) < 2760});
            last = cyc;
            prev = ramp[s];
        end
        wr(6'h00, 8'h00);
        wr(6'h22, 8'h00);
        wr(6'h23, 8'h1C);
        repeat (300) @(posedge ref_clk);
        wr(6'h22, 8'h05);
        n = 0;
        while (pwm_fan1 !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (pwm_fan1 === 1'b1 && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("spin time", 32'h1, {31'h0, n > 4380 && n < 4500});
        chk("notes left", 32'h0, 32'(notes.size()));
        end_sim();
    end
endmodule

bind afc_top afc_props chk_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .pwm_fan1, .pwm_fan2);
